// ===== include/csopt_pkg.sv
package csopt_pkg;

  // ----------------------------------------------------------------
  // Sizes and register map
  // ----------------------------------------------------------------
  localparam int          CSOPT_NUM_REGIONS = 6;
  localparam int          CSOPT_NUM_STROBES = 6;

  // Option registers of the strobe-capable pins 6 to 11, in pin order.
  localparam logic [31:0] CSOPT_STROBE_OPT_ADDR [CSOPT_NUM_STROBES] = '{
    32'h8007fdbc, 32'h8007fdb4, 32'h8007fdac,
    32'h8007fda4, 32'h8007fd9c, 32'h8007fd94
  };

  // Region option and base registers: boot region first, then regions 1 to 5.
  localparam logic [31:0] CSOPT_REGION_OPT_ADDR0  = 32'h8007fe00;
  localparam logic [31:0] CSOPT_REGION_BASE_ADDR0 = 32'h8007fe20;
  localparam logic [31:0] CSOPT_STATUS_ADDR       = 32'h8007fe40;
  localparam logic [31:0] CSOPT_WORD_STRIDE       = 32'h00000004;

  // ----------------------------------------------------------------
  // Field positions (bit 0 of the printed layout is bit 31 here)
  // ----------------------------------------------------------------
  localparam int          CSOPT_BLOCK_SIZE_LSB    = 28;
  localparam int          CSOPT_NESTED_BIT        = 27;
  localparam int          CSOPT_PRIV_BIT          = 26;
  localparam int          CSOPT_PIN_FN_LSB        = 11;
  localparam int          CSOPT_BYTE_LSB          = 9;
  localparam int          CSOPT_REGION_LSB        = 6;
  localparam int          CSOPT_BASE_LSB          = 12;

  // Writable bits; everything else is reserved and reads as zero.
  localparam logic [31:0] CSOPT_STROBE_OPT_MASK   = 32'h00001fc0;
  localparam logic [31:0] CSOPT_REGION_OPT_MASK   = 32'hfc000000;
  localparam logic [31:0] CSOPT_REGION_BASE_MASK  = 32'hfffff000;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  CSOPT_PIN_CHIP_ENABLE   = 2'h0;
  localparam logic [1:0]  CSOPT_PIN_WRITE_STROBE  = 2'h1;
  localparam logic [1:0]  CSOPT_PIN_OUTPUT_STROBE = 2'h2;
  localparam logic [1:0]  CSOPT_PIN_ALTERNATE     = 2'h3;
  localparam logic [1:0]  CSOPT_PIN_RESET_SELECT  = 2'h2;
  localparam logic [1:0]  CSOPT_PIN_RESET_OTHER   = 2'h3;
  localparam logic [2:0]  CSOPT_REGION_LAST       = 3'h5;
  localparam logic [3:0]  CSOPT_BLOCK_SIZE_OFF    = 4'h0;
  localparam int          CSOPT_BLOCK_SHIFT0      = 11;
  localparam logic [31:0] CSOPT_STROBE_OPT_RESET  = 32'h00001800;
  localparam logic [31:0] CSOPT_ZERO_WORD         = 32'h00000000;

  // Strap capture sequencer.
  typedef enum logic {
    CSOPT_ST_LOAD,
    CSOPT_ST_RUN
  } csopt_state_type;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // Address compare mask for a block size code: code 1 keeps the 20 top
  // address bits, each further code drops one more low bit.
  function automatic logic [31:0] csopt_block_mask(input logic [3:0] code);
    logic [31:0] ones;
    ones = 32'hffffffff;
    return ones << (CSOPT_BLOCK_SHIFT0 + int'(code));
  endfunction : csopt_block_mask

  // Byte address of word i in a table starting at base.
  function automatic logic [31:0] csopt_word_addr(input logic [31:0] base,
                                                  input int          i);
    return base + CSOPT_WORD_STRIDE * 32'(i);
  endfunction : csopt_word_addr

endpackage : csopt_pkg

// ===== core/csopt_region_match.sv
module csopt_region_match
  import csopt_pkg::*;
(
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] base_word,
  input  wire logic [31:0] option_word,
  input  wire logic        bus_supervisor,
  input  wire logic        bus_data_access,
  output logic             hit,
  output logic             nested,
  output logic             denied
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // The block size field sets how many high address bits take part.
  wire logic [3:0]  block_size_code = option_word[CSOPT_BLOCK_SIZE_LSB +: 4];
  wire logic [31:0] compare_mask    = csopt_block_mask(block_size_code);
  wire logic        size_valid      = block_size_code != CSOPT_BLOCK_SIZE_OFF;
  wire logic        privileged_only = option_word[CSOPT_PRIV_BIT];

  // ----------------------------------------------------------------
  // Match and protection
  // ----------------------------------------------------------------
  // A zero size code keeps the region silent whatever the base says.
  assign hit    = size_valid && ((bus_addr & compare_mask) == (base_word & compare_mask));
  assign nested = option_word[CSOPT_NESTED_BIT];
  // Only data accesses are policed; instruction fetches pass.
  assign denied = privileged_only && bus_data_access && !bus_supervisor;

endmodule : csopt_region_match

// ===== core/csopt_top.sv
// How it works
// - Pin function resets 10 if select, else 11.
// - Pins 6-11 keep only function, byte, region.
// - Block size field sets region block size.
// - Nested flag marks sub-block inside main block.
// - Privileged flag limits data access to supervisor.
// - Pin function picks enable, strobes or alternate; the enable code leaves the pin idle.
// - Size zero disables; codes double from 4K.
// - Region field binds strobe; codes 6,7 reserved.
// - Byte field picks lane gating the write strobe.
//
// The APB register port was left to the implementer.
module csopt_top
  import csopt_pkg::*;
(
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] select_strap,
  input  wire logic                         bus_valid,
  input  wire logic                         bus_write,
  input  wire logic [31:0]                  bus_addr,
  input  wire logic [3:0]                   bus_byte_en,
  input  wire logic                         bus_supervisor,
  input  wire logic                         bus_data_access,
  output logic [csopt_pkg::CSOPT_NUM_REGIONS-1:0] region_select_n,
  output logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] strobe_n,
  output logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] alt_function,
  output logic                              access_denied
);
  import csopt_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Option and base words, one flop word per register.
  logic [31:0]     strobe_opt_reg  [CSOPT_NUM_STROBES];
  logic [31:0]     region_opt_reg  [CSOPT_NUM_REGIONS];
  logic [31:0]     region_base_reg [CSOPT_NUM_REGIONS];

  // Strap capture sequencer.
  csopt_state_type state_reg;

  // Bus answer, held in flops so the bus sees no decode glitches.
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;

  // Pin registers; every pin output of the block is one of these.
  logic [CSOPT_NUM_REGIONS-1:0] region_select_n_reg;
  logic [CSOPT_NUM_STROBES-1:0] strobe_n_reg;
  logic [CSOPT_NUM_STROBES-1:0] alt_function_reg;
  logic            access_denied_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // A request is answered one cycle into its access phase, so every
  // transfer takes setup plus two access cycles.
  wire logic access_phase = psel && penable;
  wire logic capture      = access_phase && !pready_reg;
  wire logic commit       = access_phase && pready_reg;

  // Status is read-only; a write to it is accepted and dropped.
  wire logic status_hit   = paddr == CSOPT_STATUS_ADDR;

  // One hit bit per register; the map has no overlaps, so at most one
  // bit of the three vectors is set for any address.
  logic [CSOPT_NUM_STROBES-1:0] strobe_opt_hit;
  logic [CSOPT_NUM_REGIONS-1:0] region_opt_hit;
  logic [CSOPT_NUM_REGIONS-1:0] region_base_hit;

  // The strobe option words are scattered, so each has its own constant.
  for (genvar k = 0; k < CSOPT_NUM_STROBES; k++) begin : g_strobe_dec
    assign strobe_opt_hit[k] = paddr == CSOPT_STROBE_OPT_ADDR[k];
  end
  // Region option and base words form two tables, one word per
  // region, boot region first.
  for (genvar i = 0; i < CSOPT_NUM_REGIONS; i++) begin : g_region_dec
    assign region_opt_hit[i]  = paddr == csopt_word_addr(CSOPT_REGION_OPT_ADDR0, i);
    assign region_base_hit[i] = paddr == csopt_word_addr(CSOPT_REGION_BASE_ADDR0, i);
  end

  // An address outside the map is answered, but with an error, so a
  // stray access never hangs the bus.
  wire logic mapped = status_hit || (|strobe_opt_hit) || (|region_opt_hit)
                      || (|region_base_hit);

  // Reserved bits are cut off on the way in, so they always read zero.
  wire logic [31:0] strobe_opt_wdata  = pwdata & CSOPT_STROBE_OPT_MASK;
  wire logic [31:0] region_opt_wdata  = pwdata & CSOPT_REGION_OPT_MASK;
  wire logic [31:0] region_base_wdata = pwdata & CSOPT_REGION_BASE_MASK;

  // ----------------------------------------------------------------
  // Region matching
  // ----------------------------------------------------------------
  // One matcher per region; all of them compare in parallel.
  logic [CSOPT_NUM_REGIONS-1:0] region_hit;
  logic [CSOPT_NUM_REGIONS-1:0] region_nested;
  logic [CSOPT_NUM_REGIONS-1:0] region_denied;

  // Fetches and data accesses go through the same compare; only the
  // privilege check tells them apart.
  for (genvar i = 0; i < CSOPT_NUM_REGIONS; i++) begin : g_match
    csopt_region_match u_match (
      .bus_addr        (bus_addr),
      .base_word       (region_base_reg[i]),
      .option_word     (region_opt_reg[i]),
      .bus_supervisor  (bus_supervisor),
      .bus_data_access (bus_data_access),
      .hit             (region_hit[i]),
      .nested          (region_nested[i]),
      .denied          (region_denied[i])
    );
  end

  // A matching sub-block takes the access away from its main block, so
  // the two never assert together.
  wire logic any_sub_hit = |(region_hit & region_nested);
  wire logic [CSOPT_NUM_REGIONS-1:0] region_owner =
    region_hit & (region_nested | {CSOPT_NUM_REGIONS{!any_sub_hit}});

  // A denied region selects nothing and the access is flagged instead.
  wire logic [CSOPT_NUM_REGIONS-1:0] region_active =
    region_owner & ~region_denied & {CSOPT_NUM_REGIONS{bus_valid}};
  wire logic denied_now = bus_valid && (|(region_owner & region_denied));

  // ----------------------------------------------------------------
  // Strobe pins 6 to 11
  // ----------------------------------------------------------------
  // Each pin strobes for one region or hands the pin to its alternate
  // function; the two never overlap.
  logic [CSOPT_NUM_STROBES-1:0] strobe_active;
  logic [CSOPT_NUM_STROBES-1:0] strobe_alt;

  for (genvar k = 0; k < CSOPT_NUM_STROBES; k++) begin : g_strobe
    // Fields of this pin's option word.
    wire logic [1:0] pin_fn   = strobe_opt_reg[k][CSOPT_PIN_FN_LSB +: 2];
    wire logic [1:0] lane     = strobe_opt_reg[k][CSOPT_BYTE_LSB +: 2];
    wire logic [2:0] region   = strobe_opt_reg[k][CSOPT_REGION_LSB +: 3];

    // Reserved region codes bind to nothing and leave the pin idle.
    wire logic       bound    = region <= CSOPT_REGION_LAST;
    wire logic       rgn_on   = bound && region_active[region];
    wire logic       lane_on  = bus_byte_en[lane];

    // Chip enable is not a legal role for these pins; it stays quiet.
    assign strobe_active[k] =
      (pin_fn == CSOPT_PIN_WRITE_STROBE)  ? (rgn_on && bus_write && lane_on) :
      (pin_fn == CSOPT_PIN_OUTPUT_STROBE) ? (rgn_on && !bus_write) : 1'b0;
    assign strobe_alt[k] = pin_fn == CSOPT_PIN_ALTERNATE;
  end

  // ----------------------------------------------------------------
  // Read data and status
  // ----------------------------------------------------------------
  // Status shows the pins active high, so software need not invert.
  // It reads the registered pins, one cycle behind the bus inputs.
  wire logic [31:0] status_word = {15'h0000, access_denied_reg,
                                   2'h0, ~strobe_n_reg,
                                   2'h0, ~region_select_n_reg};

  // Read mux; a miss in the map reads zero.
  logic [31:0] read_word;
  always_comb begin
    // Default first, so every path leaves the mux a value.
    read_word = status_hit ? status_word : CSOPT_ZERO_WORD;
    for (int k = 0; k < CSOPT_NUM_STROBES; k++) begin
      if (strobe_opt_hit[k]) begin
        read_word = strobe_opt_reg[k];
      end
    end

    for (int i = 0; i < CSOPT_NUM_REGIONS; i++) begin
      if (region_opt_hit[i]) begin
        read_word = region_opt_reg[i];
      end
      if (region_base_hit[i]) begin
        read_word = region_base_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Ready drops right after each answer so a back-to-back request gets a
  // fresh setup and capture cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= CSOPT_ZERO_WORD;
    end else begin
      // Ready rises one edge after capture and falls at the next.
      pready_reg  <= capture;
      // The error rides with ready for that same single cycle.
      pslverr_reg <= capture && !mapped;
      // Read data is frozen at capture and held until the next one.
      if (capture) begin
        prdata_reg <= pwrite ? CSOPT_ZERO_WORD : read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobe-pin option registers
  // ----------------------------------------------------------------
  // The strap is not sampled under reset: the pin fields come up as
  // "other" and the first clock after release loads the real value.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // The strap is not trusted under reset; pins start as alternate.
      state_reg <= CSOPT_ST_LOAD;
      for (int k = 0; k < CSOPT_NUM_STROBES; k++) begin
        strobe_opt_reg[k] <= CSOPT_STROBE_OPT_RESET;
      end
    end else begin
      case (state_reg)
        CSOPT_ST_LOAD: begin
          // Only the pin fields follow the strap; the rest stay zero.
          for (int k = 0; k < CSOPT_NUM_STROBES; k++) begin
            strobe_opt_reg[k][CSOPT_PIN_FN_LSB +: 2] <= select_strap[k] ?
              CSOPT_PIN_RESET_SELECT : CSOPT_PIN_RESET_OTHER;
          end
          state_reg <= CSOPT_ST_RUN;
        end
        CSOPT_ST_RUN: begin
          // Writes are honoured only once the strap is in.
          for (int k = 0; k < CSOPT_NUM_STROBES; k++) begin
            if (commit && pwrite && strobe_opt_hit[k]) begin
              strobe_opt_reg[k] <= strobe_opt_wdata;
            end
          end
        end
        // Unreachable; resume normal running.
        default: begin
          state_reg <= CSOPT_ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Region option and base registers
  // ----------------------------------------------------------------
  // All regions come up with size zero, so nothing selects until
  // software has written an option word; the bases may then be
  // written in either order.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CSOPT_NUM_REGIONS; i++) begin
        region_opt_reg[i]  <= CSOPT_ZERO_WORD;
        region_base_reg[i] <= CSOPT_ZERO_WORD;
      end
    end else begin
      for (int i = 0; i < CSOPT_NUM_REGIONS; i++) begin
        // Reserved bits are already masked off here.
        if (commit && pwrite && region_opt_hit[i]) begin
          region_opt_reg[i] <= region_opt_wdata;
        end
        // Low base bits are dropped; no block is under 4K.
        if (commit && pwrite && region_base_hit[i]) begin
          region_base_reg[i] <= region_base_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Registering the pins costs a cycle of latency but keeps glitches
  // from the address compare off the external strobes.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Pins come up idle; selects and strobes are active low.
      region_select_n_reg <= '1;
      strobe_n_reg        <= '1;
      alt_function_reg    <= '1;
      access_denied_reg   <= 1'b0;
    end else begin
      region_select_n_reg <= ~region_active;
      strobe_n_reg        <= ~strobe_active;
      // The alternate role follows the option word alone.
      alt_function_reg    <= strobe_alt;
      access_denied_reg   <= denied_now;
    end
  end

  // Ports are plain copies of the registers.
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;

  assign region_select_n = region_select_n_reg;
  assign strobe_n        = strobe_n_reg;
  assign alt_function    = alt_function_reg;
  assign access_denied   = access_denied_reg;

endmodule : csopt_top

// ===== sim/csopt_sva.sv
module csopt_sva
  import csopt_pkg::*;
(
  input wire logic                                    ref_clk,
  input wire logic                                    resetn,
  input wire logic                                    psel,
  input wire logic                                    penable,
  input wire logic                                    pready,
  input wire logic                                    pslverr,
  input wire logic                                    bus_valid,
  input wire logic                                    bus_write,
  input wire logic [3:0]                              bus_byte_en,
  input wire logic                                    bus_supervisor,
  input wire logic                                    bus_data_access,
  input wire logic [csopt_pkg::CSOPT_NUM_REGIONS-1:0] region_select_n,
  input wire logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] strobe_n,
  input wire logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] alt_function,
  input wire logic                                    access_denied
);
  import csopt_pkg::*;

  // ----------------------------------------------------------------
  // Register bus and pin relations
  // ----------------------------------------------------------------
  // All relations live in the one clock domain.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered on the next edge");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  idle_no_select_a: assert property (!bus_valid |=> &region_select_n)
    else $error("region selected with no access");
  denied_cause_a: assert property (access_denied |->
    $past(bus_valid && bus_data_access && !bus_supervisor))
    else $error("access denied without a user data access");
  supervisor_ok_a: assert property (bus_valid && bus_supervisor |=> !access_denied)
    else $error("supervisor access denied");
  alt_no_strobe_a: assert property (&(strobe_n | ~alt_function))
    else $error("strobe on an alternate-function pin");
  strobe_region_a: assert property (strobe_n != '1 |-> region_select_n != '1)
    else $error("strobe without any selected region");
  write_lane_a: assert property (strobe_n != '1 && $past(bus_write) |->
    $past(bus_byte_en) != 4'h0)
    else $error("write strobe with no byte lane");

  // Main scenarios that the bench should reach.
  cover property (pready && pslverr);
  cover property (access_denied);
  cover property (strobe_n != '1);
endmodule : csopt_sva

bind csopt_top csopt_sva csopt_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid),
  .bus_write(bus_write), .bus_byte_en(bus_byte_en), .bus_supervisor(bus_supervisor),
  .bus_data_access(bus_data_access), .region_select_n(region_select_n),
  .strobe_n(strobe_n), .alt_function(alt_function), .access_denied(access_denied));

// ===== sim/csopt_mem_model.sv
module csopt_mem_model
  import csopt_pkg::*;
(
  input  wire logic                                    ref_clk,
  input  wire logic                                    resetn,
  input  wire logic [csopt_pkg::CSOPT_NUM_REGIONS-1:0] region_select_n,
  input  wire logic [csopt_pkg::CSOPT_NUM_STROBES-1:0] strobe_n,
  output int                                           strobe_cnt,
  output int                                           stray_cnt
);
  import csopt_pkg::*;
  logic [CSOPT_NUM_STROBES-1:0] last_n;

  // Count each strobe once on its falling edge; a strobe with no region
  // selected would hit a memory that is not enabled, so it is counted apart.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      last_n     <= '1;
      strobe_cnt <= 0;
      stray_cnt  <= 0;
    end else begin
      last_n     <= strobe_n;
      strobe_cnt <= strobe_cnt + $countones(last_n & ~strobe_n);
      if (strobe_n != '1 && region_select_n == '1) begin
        stray_cnt <= stray_cnt + 1;
      end
    end
  end
endmodule : csopt_mem_model

// ===== sim/testbench.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import csopt_pkg::*;

  logic        ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        bus_valid = 0, bus_write = 0, bus_supervisor = 0, bus_data_access = 0;
  logic [31:0] paddr = 0, pwdata = 0, bus_addr = 0, prdata, rd;
  logic [3:0]  bus_byte_en = 0;
  logic [5:0]  select_strap = 6'h05, region_select_n, strobe_n, alt_function;
  logic        pready, pslverr, access_denied, err;
  int          mismatches = 0, num_checks = 0, exp_strobes = 0, strobe_cnt, stray_cnt;
  logic [31:0] sz, base;

  always #25 ref_clk = ~ref_clk;

  csopt_top csopt_top_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .select_strap(select_strap), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_byte_en(bus_byte_en),
    .bus_supervisor(bus_supervisor), .bus_data_access(bus_data_access),
    .region_select_n(region_select_n), .strobe_n(strobe_n), .alt_function(alt_function),
    .access_denied(access_denied));
  csopt_mem_model csopt_mem_model_inst (.ref_clk(ref_clk), .resetn(resetn),
    .region_select_n(region_select_n), .strobe_n(strobe_n), .strobe_cnt(strobe_cnt),
    .stray_cnt(stray_cnt));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic e_err);
    apb(1'b0, a, 32'h00000000);
    `CHK(rd, e)
    `CHK(err, e_err)
  endtask : rd_chk

  // One core access; the outputs register one edge after the inputs.
  task automatic acc(input logic [31:0] a, input logic wr, input logic [3:0] be,
                     input logic sup, input logic dat, input logic [5:0] sel,
                     input logic [5:0] stb, input logic den);
    @(posedge ref_clk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_write <= wr;
    bus_byte_en <= be;
    bus_supervisor <= sup;
    bus_data_access <= dat;
    @(posedge ref_clk);
    #1;
    `CHK(region_select_n, ~sel)
    `CHK(strobe_n, ~stb)
    `CHK(access_denied, den)
    exp_strobes += $countones(stb);
    @(posedge ref_clk);
    bus_valid <= 1'b0;
  endtask : acc

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Region 1 sits at a base aligned to the largest block tested, so every tested size (codes 1 to 12) fits.
  initial begin
    base = 32'h01000000;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 6; k++) begin
      rd_chk(CSOPT_STROBE_OPT_ADDR[k], select_strap[k] ? 32'h00001000 : 32'h00001800, 1'b0);
    end
    `CHK(alt_function, ~select_strap)
    $display("test reset done");
    apb(1'b1, CSOPT_STROBE_OPT_ADDR[5], 32'hffffffff);
    rd_chk(CSOPT_STROBE_OPT_ADDR[5], 32'h00001fc0, 1'b0);
    rd_chk(32'h8007fd98, 32'h00000000, 1'b1);
    rd_chk(CSOPT_STATUS_ADDR, 32'h00000000, 1'b0);
    // Pin 6 write strobe lane 2, pin 7 output strobe, pin 10 bad region, pin 11 enable role.
    apb(1'b1, CSOPT_STROBE_OPT_ADDR[0], 32'h00000c40);
    apb(1'b1, CSOPT_STROBE_OPT_ADDR[1], 32'h00001040);
    apb(1'b1, CSOPT_STROBE_OPT_ADDR[4], 32'h00001180);
    apb(1'b1, CSOPT_STROBE_OPT_ADDR[5], 32'h00000040);
    apb(1'b1, CSOPT_REGION_BASE_ADDR0 + 32'h4, base);
    @(posedge ref_clk);
    `CHK(alt_function, 6'h08)
    $display("test registers done");
    for (int n = 1; n <= 12; n++) begin
      sz = 32'h00001000 << (n - 1);
      apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h4, 32'(n) << 28);
      acc(base + sz - 32'h4, 1'b0, 4'h0, 1'b1, 1'b1, 6'h02, 6'h02, 1'b0);
      acc(base + sz, 1'b0, 4'h0, 1'b1, 1'b1, 6'h00, 6'h00, 1'b0);
    end
    apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h4, 32'h00000000);
    acc(base, 1'b0, 4'h0, 1'b1, 1'b1, 6'h00, 6'h00, 1'b0);
    apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h4, 32'h10000000);
    acc(base, 1'b1, 4'h4, 1'b1, 1'b1, 6'h02, 6'h01, 1'b0);
    acc(base, 1'b1, 4'hb, 1'b1, 1'b1, 6'h02, 6'h00, 1'b0);
    $display("test size done");
    apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h4, 32'h14000000);
    acc(base, 1'b0, 4'h0, 1'b0, 1'b1, 6'h00, 6'h00, 1'b1);
    acc(base, 1'b0, 4'h0, 1'b0, 1'b0, 6'h02, 6'h02, 1'b0);
    acc(base, 1'b0, 4'h0, 1'b1, 1'b1, 6'h02, 6'h02, 1'b0);
    $display("test privilege done");
    apb(1'b1, CSOPT_REGION_BASE_ADDR0 + 32'h8, base);
    apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h8, 32'h50000000);
    acc(base, 1'b0, 4'h0, 1'b1, 1'b1, 6'h06, 6'h02, 1'b0);
    apb(1'b1, CSOPT_REGION_OPT_ADDR0 + 32'h4, 32'h18000000);
    acc(base, 1'b0, 4'h0, 1'b1, 1'b1, 6'h02, 6'h02, 1'b0);
    acc(base + 32'h2000, 1'b0, 4'h0, 1'b1, 1'b1, 6'h04, 6'h00, 1'b0);
    repeat (3) @(posedge ref_clk);
    `CHK(strobe_cnt, exp_strobes)
    `CHK(stray_cnt, 0)
    $display("test nesting done");
    conclude();
  end

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #200us;
    mismatches++;
    conclude();
  end
endmodule : testbench
